/* rtl/lss_pkg.sv */
// Shared constants and types for the linear sensor scan link
package lss_pkg;

  // Clock of both ends, 25 MHz
  localparam int CLK_PERIOD_NS      = 40;
  // Counter and pixel widths, output FIFO depth
  localparam int CNT_W              = 13;
  localparam int PIX_W              = 12;
  localparam int FIFO_DEPTH         = 16;
  // Scan geometry and start pulse limits, in clock periods
  localparam int PIXEL_COUNT        = 4096;
  localparam int FIRST_VALID_STROBE = 89;
  localparam int LAST_STROBE        = FIRST_VALID_STROBE + PIXEL_COUNT - 1;
  localparam int INTEG_EXTRA        = 48;
  localparam int START_HIGH_MIN     = 6;
  localparam int START_LOW_MIN      = 100;
  localparam int START_PERIOD_MIN   = 106;
  localparam int START_PERIOD_REC   = 4188;

  // Same figures at counter width for comparisons
  localparam logic [CNT_W-1:0] FIRST_STB_C  = 13'h0059;
  localparam logic [CNT_W-1:0] LAST_STB_C   = 13'h1058;
  localparam logic [CNT_W-1:0] INTEG_EXTRA_C = 13'h0030;
  localparam logic [CNT_W-1:0] HIGH_MIN_C   = 13'h0006;
  localparam logic [CNT_W-1:0] LOW_MIN_C    = 13'h0064;
  localparam logic [CNT_W-1:0] CNT_ONE      = 13'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX      = 13'h1fff;

  // Sensor readout state
  typedef enum logic [0:0] {
    LSS_IDLE = 1'b0,
    LSS_RUN  = 1'b1
  } lss_sens_state_t;

  // Controller start pulse phase
  typedef enum logic [0:0] {
    LSS_LOW  = 1'b0,
    LSS_HIGH = 1'b1
  } lss_ctrl_state_t;

endpackage : lss_pkg

/* rtl/lss_link_if.sv */
// Link between the sensor and its timing controller
`timescale 1ns/10ps
`default_nettype none
interface lss_link_if
  import lss_pkg::*;
();
  logic             scanStart;     // scan_start_pulse, controller to sensor
  logic [PIX_W-1:0] video;         // Digitised stand-in for the analog pixel level
  logic             sampleStrobe;  // One per pixel clock during readout
  logic             scanEnd;       // scan_end_flag, one cycle after the last pixel

  modport sensor (
    input  scanStart,
    output video,
    output sampleStrobe,
    output scanEnd
  );

  modport ctrl (
    output scanStart,
    input  video,
    input  sampleStrobe,
    input  scanEnd
  );
endinterface : lss_link_if
`default_nettype wire

/* rtl/lss_sensor_end.sv */
// Sensor end: integration timing, serial pixel readout, strobe and end flag
`timescale 1ns/10ps
`default_nettype none
module lss_sensor_end
  import lss_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  lss_link_if.sensor            link,
  input  wire logic [PIX_W-1:0] lightLevel,
  output logic      [CNT_W-1:0] integTime,
  output logic                  scanActive
);

  lss_sens_state_t  state_q;
  logic             startQ_q;
  logic [CNT_W-1:0] highCnt_q;
  logic [CNT_W-1:0] strobeCnt_q;
  logic [CNT_W-1:0] integ_q;
  logic             firstScan_q;
  logic [PIX_W-1:0] video_q;
  logic             strobe_q;
  logic             scanEnd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Edge decode and next strobe number
  wire              riseSeen  = link.scanStart & ~startQ_q;
  wire              fallSeen  = ~link.scanStart & startQ_q;
  wire              lastStb   = (state_q == LSS_RUN) && (strobeCnt_q == LAST_STB_C);
  wire              stepStb   = ((state_q == LSS_IDLE) && fallSeen) || ((state_q == LSS_RUN) && !lastStb);
  wire [CNT_W-1:0]  nextCnt   = strobeCnt_q + CNT_ONE;
  wire              inPixels  = (nextCnt >= FIRST_STB_C) && (nextCnt <= LAST_STB_C);
  wire [CNT_W-1:0]  pixIdx    = nextCnt - FIRST_STB_C;
  // First scan after reset carries no meaningful charge, shown as full scale
  wire [PIX_W-1:0]  pixVal    = firstScan_q ? {PIX_W{1'b1}} : lightLevel + pixIdx[PIX_W-1:0];
  wire [CNT_W-1:0]  highNext  = (highCnt_q == CNT_MAX) ? highCnt_q : highCnt_q + CNT_ONE;

  ////////////////////////////////////////////////////////////////////////////
  // Integration: count high periods, add the fixed tail on the falling edge
  // The counter saturates at 8191, but integTime wraps once the count passes 8143
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      startQ_q  <= 1'b0;
      highCnt_q <= '0;
      integ_q   <= '0;
    end else begin
      startQ_q <= link.scanStart;
      if (riseSeen) begin
        highCnt_q <= CNT_ONE;
      end else if (link.scanStart) begin
        highCnt_q <= highNext;
      end
      if (fallSeen) begin
        integ_q <= highCnt_q + INTEG_EXTRA_C;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readout: the edge that sees the start pulse low is the first shift edge
  // A new falling edge during readout is ignored; the controller spaces them
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q     <= LSS_IDLE;
      strobeCnt_q <= '0;
      strobe_q    <= 1'b0;
      scanEnd_q   <= 1'b0;
      video_q     <= '0;
      firstScan_q <= 1'b1;
    end else begin
      scanEnd_q <= lastStb;
      if (stepStb) begin
        state_q     <= LSS_RUN;
        strobeCnt_q <= nextCnt;
        strobe_q    <= 1'b1;
        video_q     <= inPixels ? pixVal : '0;
      end else begin
        state_q     <= LSS_IDLE;
        strobeCnt_q <= '0;
        strobe_q    <= 1'b0;
        if (lastStb) begin
          firstScan_q <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link and user outputs
  assign link.video        = video_q;
  assign link.sampleStrobe = strobe_q;
  assign link.scanEnd      = scanEnd_q;
  assign integTime         = integ_q;
  assign scanActive        = strobe_q;

endmodule : lss_sensor_end
`default_nettype wire

/* rtl/lss_ctrl_end.sv */
// Controller end: start pulse generator, pixel capture and output FIFO
//
// Behaviour
// - Start low at least 100, period 106.
// - Start high at least 6 clock periods.
// - Shifting starts first clock after falling edge.
// - Integration equals high time plus 48.
// - Exposure set only by high/low split.
// - First valid pixel at 89th strobe.
// - One strobe per pixel, sample on it.
// - Discard first scan after power-on.
// - Recommended start period 4188 clock periods.
// - Sensor needs only start pulse and clock.
// - 4096 pixels, one per clock period.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO, registered storage, valid/ready on both sides
module lss_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 16
) (
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] inData,
  input  wire logic         inValid,
  output logic              inReady,
  output logic      [W-1:0] outData,
  output logic              outValid,
  input  wire logic         outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wrPtr_q;
  logic [AW:0]  rdPtr_q;

  // Extra pointer bit tells full from empty
  wire empty = (wrPtr_q == rdPtr_q);
  wire full  = (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) && (wrPtr_q[AW] != rdPtr_q[AW]);
  wire push  = inValid & ~full;
  wire pop   = outReady & ~empty;

  assign inReady  = ~full;
  assign outValid = ~empty;
  assign outData  = mem_q[rdPtr_q[AW-1:0]];

  // Storage has no reset; pointers guard every read
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  // Pointer update
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + 1'b1;
      if (pop) rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
endmodule : lss_fifo

////////////////////////////////////////////////////////////////////////////
// Controller end
module lss_ctrl_end
  import lss_pkg::*;
#(
  parameter int START_PERIOD = START_PERIOD_REC,
  parameter int DEPTH        = FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  lss_link_if.ctrl              link,
  input  wire logic             enable,
  input  wire logic [CNT_W-1:0] expoHigh,
  output logic      [PIX_W-1:0] pixData,
  output logic                  pixValid,
  input  wire logic             pixReady,
  output logic                  scanDone,
  output logic                  dataValid,
  output logic                  overflow
);

  lss_ctrl_state_t  state_q;
  logic [CNT_W-1:0] periodCnt_q;
  logic [CNT_W-1:0] highLen_q;
  logic             start_q;
  logic [CNT_W-1:0] stbCnt_q;
  logic             capture_q;
  logic             validScan_q;
  logic             scanDone_q;
  logic             overflow_q;
  logic             fifoInReady;
  logic [CNT_W-1:0] sinceFall_q;

  ////////////////////////////////////////////////////////////////////////////
  // High phase length, clamped so both phase minimums always hold
  wire [CNT_W-1:0] periodC  = START_PERIOD[CNT_W-1:0];
  wire [CNT_W-1:0] highMax  = periodC - LOW_MIN_C;
  wire [CNT_W-1:0] highReq  = (expoHigh < HIGH_MIN_C) ? HIGH_MIN_C :
                              (expoHigh > highMax) ? highMax : expoHigh;
  wire             endHigh  = (state_q == LSS_HIGH) && (periodCnt_q == highLen_q - CNT_ONE);
  wire             periodUp = (periodCnt_q >= periodC - CNT_ONE);
  // A short exposure after a long one would fall mid-readout and be ignored,
  // so the rise waits until the coming fall lands after the readout ends
  wire [CNT_W:0]   fallGap  = {1'b0, sinceFall_q} + {1'b0, highReq};
  wire [CNT_W:0]   readSpan = {1'b0, LAST_STB_C} + {1'b0, CNT_ONE} + {1'b0, CNT_ONE};
  wire             readFree = (fallGap >= readSpan);
  // Full FIFO holds off the next scan rather than losing a later one
  wire             goHigh   = (state_q == LSS_LOW) && periodUp && enable && fifoInReady && readFree;
  wire [CNT_W-1:0] cntNext  = periodUp ? periodCnt_q : periodCnt_q + CNT_ONE;

  ////////////////////////////////////////////////////////////////////////////
  // Start pulse generator; period counted from each rising edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q     <= LSS_LOW;
      periodCnt_q <= '0;
      highLen_q   <= HIGH_MIN_C;
      start_q     <= 1'b0;
    end else begin
      case (state_q)
        LSS_LOW: begin
          if (goHigh) begin
            state_q     <= LSS_HIGH;
            periodCnt_q <= '0;
            highLen_q   <= highReq;
            start_q     <= 1'b1;
          end else begin
            periodCnt_q <= cntNext;
          end
        end
        LSS_HIGH: begin
          periodCnt_q <= cntNext;
          if (endHigh) begin
            state_q <= LSS_LOW;
            start_q <= 1'b0;
          end
        end
        default: begin
          state_q <= LSS_LOW;
          start_q <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycles since our last falling edge; saturates so long idle never wraps
  wire [CNT_W-1:0] fallNext = (sinceFall_q == CNT_MAX) ? sinceFall_q : sinceFall_q + CNT_ONE;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sinceFall_q <= CNT_MAX;
    end else if (endHigh) begin
      sinceFall_q <= '0;
    end else begin
      sinceFall_q <= fallNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe counting from the falling edge and pixel selection
  wire [CNT_W-1:0] stbNext = stbCnt_q + CNT_ONE;
  wire             inPix   = (stbNext >= FIRST_STB_C) && (stbNext <= LAST_STB_C);
  wire             sample  = link.sampleStrobe && capture_q && inPix && validScan_q;
  wire             push    = sample && fifoInReady;

  // Capture window opens with our own falling edge, closes on the end flag
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stbCnt_q    <= '0;
      capture_q   <= 1'b0;
      validScan_q <= 1'b0;
      scanDone_q  <= 1'b0;
      overflow_q  <= 1'b0;
    end else begin
      scanDone_q <= link.scanEnd;
      if (endHigh) begin
        stbCnt_q  <= '0;
        capture_q <= 1'b1;
      end else if (link.scanEnd) begin
        capture_q   <= 1'b0;
        validScan_q <= 1'b1;
      end else if (link.sampleStrobe && capture_q) begin
        stbCnt_q <= stbNext;
      end
      if (sample && !fifoInReady) begin
        overflow_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel buffer toward the user
  lss_fifo #(
    .W     (PIX_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .inData   (link.video),
    .inValid  (push),
    .inReady  (fifoInReady),
    .outData  (pixData),
    .outValid (pixValid),
    .outReady (pixReady)
  );

  // The link clock is core_clk itself, free running
  assign link.scanStart = start_q;
  assign scanDone       = scanDone_q;
  assign dataValid      = validScan_q;
  assign overflow       = overflow_q;

endmodule : lss_ctrl_end
`default_nettype wire

/* tb/lss_link_checker.sv */
// Concurrent checks on the link between the sensor end and the controller end
`timescale 1ns/10ps
`default_nettype none
module lss_link_checker
  import lss_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             arst_n,
  input wire logic             scanStart,
  input wire logic [PIX_W-1:0] video,
  input wire logic             sampleStrobe,
  input wire logic             scanEnd
);
  logic [CNT_W-1:0] lowCnt_q, highCnt_q, perCnt_q, stbCnt_q;
  logic             prevSt_q, seen_q;

  ////////////////////////////////////////////////////////////////////////////
  // Saturating run counters, so long idle stretches never wrap to small values
  function automatic logic [CNT_W-1:0] sat(input logic [CNT_W-1:0] v);
    return (v == CNT_MAX) ? v : v + CNT_ONE;
  endfunction : sat

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {lowCnt_q, highCnt_q, perCnt_q, stbCnt_q, prevSt_q, seen_q} <= '0;
    end else begin
      lowCnt_q  <= scanStart ? '0 : sat(lowCnt_q);
      highCnt_q <= scanStart ? sat(highCnt_q) : '0;
      perCnt_q  <= (scanStart && !prevSt_q) ? CNT_ONE : sat(perCnt_q);
      stbCnt_q  <= sampleStrobe ? sat(stbCnt_q) : '0;
      prevSt_q  <= scanStart;
      seen_q    <= seen_q | scanEnd;  // First scan carries no image
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start pulse shape, strobe run, end flag and pixel order
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  property p_low_min; $rose(scanStart) |-> lowCnt_q >= LOW_MIN_C; endproperty
  a_low_min: assert property (p_low_min) else $error("start low phase too short");
  property p_period; $rose(scanStart) |-> perCnt_q >= START_PERIOD_MIN; endproperty
  a_period: assert property (p_period) else $error("start period too short");
  property p_high_min; $fell(scanStart) |-> highCnt_q >= HIGH_MIN_C; endproperty
  a_high_min: assert property (p_high_min) else $error("start high phase too short");
  property p_shift; $fell(scanStart) |-> !sampleStrobe ##1 sampleStrobe; endproperty
  a_shift: assert property (p_shift) else $error("readout did not start after start fell");
  property p_run_len; $fell(sampleStrobe) |-> stbCnt_q == LAST_STB_C; endproperty
  a_run_len: assert property (p_run_len) else $error("wrong strobe count in a scan");
  property p_end_flag; $fell(sampleStrobe) |-> scanEnd ##1 !scanEnd; endproperty
  a_end_flag: assert property (p_end_flag) else $error("end flag missing or too long");
  property p_end_only; scanEnd |-> $past(sampleStrobe) && !sampleStrobe; endproperty
  a_end_only: assert property (p_end_only) else $error("end flag outside scan end");
  property p_dummy; sampleStrobe && seen_q && stbCnt_q < 13'h0058 |-> video == '0; endproperty
  a_dummy: assert property (p_dummy) else $error("dummy strobe carried data");
  property p_step;
    sampleStrobe && seen_q && stbCnt_q >= FIRST_STB_C |-> video == $past(video) + 12'h001;
  endproperty
  a_step: assert property (p_step) else $error("pixel order broken");
  c_scan: cover property ($fell(sampleStrobe));
  c_overlap: cover property ($rose(scanStart) && sampleStrobe);
  c_first: cover property (sampleStrobe && seen_q && stbCnt_q == 13'h0058);
endmodule : lss_link_checker
`default_nettype wire

/* tb/test_linear_sensor_scan_timing.sv */
// Bench for the sensor end and controller end joined by the link
`timescale 1ns/10ps
`default_nettype none
module test_linear_sensor_scan_timing
  import lss_pkg::*;
;
  localparam int SP = 4190;  // Just above the 4187 that the controller needs to fit one readout
  logic             core_clk, arst_n, enable, pixReady, stall, prevSt, fallSeen;
  logic [CNT_W-1:0] expoHigh, expHigh, integTime;
  logic [PIX_W-1:0] lightLevel, idx, pixData;
  logic             pixValid, scanDone, dataValid, overflow, scanActive;
  int               num_errors, tests_run, seed, cyc, hiCnt, popCnt, doneCnt, tab, mark, actCnt;
  logic [CNT_W-1:0] expoTab [6] = '{13'h0005, 13'h0ffb, 13'h0006, 13'h1fff, 13'h0ffa, 13'h0007};

  lss_link_if i_lss_link_if ();
  lss_sensor_end i_lss_sensor_end (.core_clk(core_clk), .arst_n(arst_n), .link(i_lss_link_if.sensor),
    .lightLevel(lightLevel), .integTime(integTime), .scanActive(scanActive));
  lss_ctrl_end #(.START_PERIOD(SP), .DEPTH(FIFO_DEPTH)) i_lss_ctrl_end (.core_clk(core_clk), .arst_n(arst_n),
    .link(i_lss_link_if.ctrl), .enable(enable), .expoHigh(expoHigh), .pixData(pixData), .pixValid(pixValid),
    .pixReady(pixReady), .scanDone(scanDone), .dataValid(dataValid), .overflow(overflow));
  lss_link_checker i_lss_link_checker (.core_clk(core_clk), .arst_n(arst_n), .scanStart(i_lss_link_if.scanStart),
    .video(i_lss_link_if.video), .sampleStrobe(i_lss_link_if.sampleStrobe), .scanEnd(i_lss_link_if.scanEnd));

  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks, expectation and closing report
  task automatic chkW(input string nm, input logic [CNT_W-1:0] e, input logic [CNT_W-1:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chkW
  task automatic chkBit(input string nm, input logic e, input logic g);
    chkW(nm, {12'h000, e}, {12'h000, g});
  endtask : chkBit
  task automatic chkCnt(input string nm, input int e, input int g);
    tests_run++;
    if (g != e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chkCnt
  function automatic logic [CNT_W-1:0] expClamp(input logic [CNT_W-1:0] v);
    if (v < HIGH_MIN_C) return HIGH_MIN_C;
    if (v > SP - START_LOW_MIN) return 13'(SP - START_LOW_MIN);
    return v;
  endfunction : expClamp
  task automatic end_sim();
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // Ends a run after the next fall; the low phase leaves room before any new rise
  task automatic stopScan();
    wait (i_lss_link_if.scanStart === 1'b1);
    wait (i_lss_link_if.scanStart === 1'b0);
    #1 enable = 1'b0;
  endtask : stopScan
  task automatic waitIdle();
    int n;
    n = 0;
    while (n < 300) begin
      @(posedge core_clk);
      n = (pixValid === 1'b0 && i_lss_link_if.sampleStrobe === 1'b0) ? n + 1 : 0;
    end
    // Step off the edge so the caller's input changes never race the design
    #1;
  endtask : waitIdle

  ////////////////////////////////////////////////////////////////////////////
  // Clock, then a sampled monitor of the link and the pixel stream
  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (arst_n) begin
      if (fallSeen) begin
        chkW("integTime", expHigh + INTEG_EXTRA_C, integTime);
        chkCnt("highLen", int'(expHigh), hiCnt);
      end
      fallSeen = prevSt && !i_lss_link_if.scanStart;
      if (i_lss_link_if.scanStart && !prevSt) begin
        expHigh = expClamp(expoHigh);
        hiCnt = 0;
        expoHigh <= #1 (tab < 6) ? expoTab[tab] : 13'($random(seed));
        tab++;
      end
      if (i_lss_link_if.scanStart) hiCnt++;
      prevSt = i_lss_link_if.scanStart;
      if (pixValid === 1'b1) chkBit("dataValid", 1'b1, dataValid);
      if (pixValid === 1'b1 && pixReady) begin
        chkW("pixData", {1'b0, lightLevel + idx}, {1'b0, pixData});
        idx++;
        popCnt++;
      end
      if (scanActive === 1'b1) actCnt++;
      if (i_lss_link_if.scanEnd === 1'b1) chkBit("dataValidAtEnd", doneCnt != 0, dataValid);
      if (scanDone === 1'b1) begin
        chkCnt("activeLen", LAST_STROBE, actCnt);
        actCnt = 0;
        doneCnt++;
      end
      pixReady <= #1 !stall && (($random(seed) & 32'h3ff) != 0);  // Rare stalls, FIFO absorbs them
      cyc++;
      if (cyc == 90000) begin
        num_errors++;
        end_sim();
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two runs at different light levels, then fill and drain the buffer
  initial begin
    seed = 32'hefe56e7b;
    {core_clk, arst_n, enable, stall, prevSt, fallSeen} = '0;
    {num_errors, tests_run, cyc, hiCnt, popCnt, doneCnt, tab, actCnt} = '0;
    {pixReady, expoHigh, idx} = {1'b1, 13'h0000, 12'h000};
    lightLevel = 12'($random(seed));
    repeat (12) @(posedge core_clk);
    #1 arst_n = 1'b1;
    enable = 1'b1;
    wait (doneCnt == 4);
    stopScan();
    waitIdle();
    chkCnt("pops", PIXEL_COUNT * (doneCnt - 1), popCnt);
    chkBit("overflow", 1'b0, overflow);
    lightLevel = 12'($random(seed));
    enable = 1'b1;
    wait (doneCnt == 6);
    stopScan();
    waitIdle();
    chkCnt("pops", PIXEL_COUNT * (doneCnt - 1), popCnt);
    mark = doneCnt;
    stall = 1'b1;
    enable = 1'b1;
    stopScan();
    wait (doneCnt == mark + 1);
    @(posedge core_clk);
    #1;
    chkBit("overflow", 1'b1, overflow);
    chkBit("pixValid", 1'b1, pixValid);
    mark = popCnt;
    stall = 1'b0;
    waitIdle();
    chkCnt("drained", mark + FIFO_DEPTH, popCnt);
    end_sim();
  end
endmodule : test_linear_sensor_scan_timing
`default_nettype wire
